// *** inc/msc_defs.svh ***
// constants for the meter scaling and capture logic
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_CLK_HZ        100000000
`define MSC_SCROLL_S      4
`define MSC_CAL_ZERO_S    8
`define MSC_DISP_MIN      (-32'sd19999)
`define MSC_DISP_MAX      (32'sd99999)
`define MSC_INP_MAX       (32'sd29999)
`define MSC_DELAY_MAX     16'h270f
`define MSC_CODE_DEFAULTS 8'h42
`define MSC_CODE_VERSION  8'h32
`define MSC_CAL_HALF_RNG  2'h3
// register byte addresses
`define MSC_A_CTRL    12'h000
`define MSC_A_INP1    12'h004
`define MSC_A_DSP1    12'h008
`define MSC_A_INP2    12'h00c
`define MSC_A_DSP2    12'h010
`define MSC_A_OFFSET  12'h014
`define MSC_A_DELAY   12'h018
`define MSC_A_LIVE    12'h01c
`define MSC_A_MINV    12'h020
`define MSC_A_MAXV    12'h024
`define MSC_A_SHOWN   12'h028
`define MSC_A_STATUS  12'h02c
`define MSC_A_CMD     12'h030
// ctrl fields
`define MSC_C_FN_LSB   0
`define MSC_C_ASG_LSB  4
`define MSC_C_MAXEN    6
`define MSC_C_MINEN    7
`define MSC_C_SCROLL   8
`define MSC_C_APPLY    9
`define MSC_C_ZOR      10
`define MSC_C_BACKLIT  11
`endif

// *** inc/msc_pkg.sv ***
// types for the meter scaling and capture logic
package msc_pkg;
  typedef enum logic [3:0] {
    MSC_FN_NONE  = 4'h0,
    MSC_FN_LOCK  = 4'h1,
    MSC_FN_ZERO  = 4'h2,
    MSC_FN_RESET = 4'h3,
    MSC_FN_HOLD  = 4'h4,
    MSC_FN_ADV   = 4'h5,
    MSC_FN_INTEN = 4'h6,
    MSC_FN_COLOR = 4'h7,
    MSC_FN_PRINT = 4'h8,
    MSC_FN_PRRST = 4'h9,
    MSC_FN_SP1   = 4'ha,
    MSC_FN_SP2   = 4'hb,
    MSC_FN_SP12  = 4'hc
  } msc_fn_t;
  typedef enum logic [1:0] {
    MSC_ASG_INPUT = 2'h0,
    MSC_ASG_MIN   = 2'h1,
    MSC_ASG_MAX   = 2'h2,
    MSC_ASG_BOTH  = 2'h3
  } msc_asg_t;
  typedef enum logic [2:0] {
    MSC_SV_IDLE  = 3'h0,
    MSC_SV_RESET = 3'h1,
    MSC_SV_VER   = 3'h2,
    MSC_SV_CALZ  = 3'h3,
    MSC_SV_CALF  = 3'h4
  } msc_sv_t;
endpackage : msc_pkg

// *** logic/msc_capture.sv ***
// delayed extreme capture for one of min or max
`timescale 1ns/100ps
`include "msc_defs.svh"
module msc_capture #(
  parameter bit IS_MAX = 1'b1
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // control
  input  wire logic               enable,
  input  wire logic               sec_tick,
  input  wire logic        [15:0] delay_s,
  input  wire logic               load,
  // values
  input  wire logic signed [31:0] live,
  output logic signed [31:0]      extreme
);
  logic [15:0] secs;
  logic        beyond;
  assign beyond = IS_MAX ? (live > extreme) : (live < extreme);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secs    <= 16'h0000;
      extreme <= 32'sd0;
    end else if (load) begin
      secs    <= 16'h0000;
      extreme <= live;
    end else if (!enable) begin
      secs    <= 16'h0000;
    end else if (!beyond) begin
      secs    <= 16'h0000;
    end else if (secs >= delay_s) begin
      extreme <= live;
      secs    <= 16'h0000;
    end else if (sec_tick) begin
      secs    <= secs + 16'h0001;
    end
  end
  a_capture_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable && !load) |=> $stable(extreme))
    else $error("extreme changed while capture disabled");
  a_spike_no_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (!beyond && !load) |=> (secs == 16'h0000))
    else $error("delay timer not restarted");
endmodule : msc_capture

// *** logic/msc_scaler.sv ***
// two point linear scaling with extrapolation
`timescale 1ns/100ps
`include "msc_defs.svh"
module msc_scaler (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // scaling points
  input  wire logic signed [31:0] inp1,
  input  wire logic signed [31:0] dsp1,
  input  wire logic signed [31:0] inp2,
  input  wire logic signed [31:0] dsp2,
  input  wire logic signed [31:0] offset,
  // reading
  input  wire logic signed [31:0] raw,
  output logic signed [31:0]      scaled
);
  logic signed [63:0] num;
  logic signed [31:0] den;
  logic signed [63:0] q;
  assign den = (inp2 == inp1) ? 32'sd1 : (inp2 - inp1);
  assign num = 64'(raw - inp1) * 64'(dsp2 - dsp1);
  assign q   = num / 64'(den);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scaled <= 32'sd0;
    end else begin
      scaled <= dsp1 + q[31:0] + offset;
    end
  end
endmodule : msc_scaler

// *** logic/msc_meter.sv ***
// display processing core of the panel current meter
// Behaviour
// - scaling display values are signed, limited to -19999 through 99999
// - key-in second input value accepted from 0 up to 29999
// - apply style: show stored input, rst goes live, select stores shown
// - beyond the points the line through both pairs is extended
// - zero function edge adjusts offset so input display reads zero
// - reset function edge loads assigned min/max with present input
// - hold function freezes assigned display while input stays active
// - select function edge advances shown display by one enabled position
// - backlit: intensity edge raises level, wrapping from 5 back to 1, color edge toggles color
// - print and reset: request transmit first, then reset assigned values
// - setpoint reset functions clear output 1, 2 or both
// - assignment used only for reset, hold and print and reset
// - max captured after display stays above it for the delay
// - min captured after display stays below it for the delay
// - each capture runs only while its own enable is set
// - code 66 restores defaults, shows reset, returns to code prompt
// - code 50 shows version, then returns to code prompt
// - calibration zero step shows busy for about 8 seconds
// - full scale step uses 100 mA on the 200 mA range
// - zero on reset only when assigned input and input shown
// - scroll advances every 4 seconds, only with min or max enabled
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "msc_defs.svh"
module msc_meter #(
  parameter int CLK_HZ = `MSC_CLK_HZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and reading
  input  wire logic        user_in,
  input  wire logic        rst_btn,
  input  wire logic [31:0] raw_reading,
  // outputs
  output logic [31:0]      display_value,
  output logic [1:0]       shown_sel,
  output logic             print_req,
  output logic             sp1_clear,
  output logic             sp2_clear,
  output logic [2:0]       intensity,
  output logic             color_green,
  output logic             cal_busy
);
  localparam int SEC_CYC = CLK_HZ;
  localparam int CALZ_S  = `MSC_CAL_ZERO_S;
  localparam int SCRL_S  = `MSC_SCROLL_S;

  function automatic logic signed [31:0] clampv(input logic signed [31:0] v,
                                                input logic signed [31:0] lo,
                                                input logic signed [31:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  // synchronisers
  logic [1:0] ui_s;
  logic [1:0] rb_s;
  logic       ui_d;
  logic       rb_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ui_s <= 2'h0;
      rb_s <= 2'h0;
      ui_d <= 1'b0;
      rb_d <= 1'b0;
    end else begin
      ui_s <= {ui_s[0], user_in};
      rb_s <= {rb_s[0], rst_btn};
      ui_d <= ui_s[1];
      rb_d <= rb_s[1];
    end
  end
  logic ui_edge;
  logic rb_edge;
  assign ui_edge = ui_s[1] & ~ui_d;
  assign rb_edge = rb_s[1] & ~rb_d;

  // registers
  logic [11:0]        ctrl;
  logic signed [31:0] inp1;
  logic signed [31:0] dsp1;
  logic signed [31:0] inp2;
  logic signed [31:0] dsp2;
  logic signed [31:0] offset;
  logic [31:0]        delays;
  logic               apply_live;
  msc_pkg::msc_fn_t   fn;
  msc_pkg::msc_asg_t  asg;
  logic               max_en;
  logic               min_en;
  assign fn     = msc_pkg::msc_fn_t'(ctrl[`MSC_C_FN_LSB +: 4]);
  assign asg    = msc_pkg::msc_asg_t'(ctrl[`MSC_C_ASG_LSB +: 2]);
  assign max_en = ctrl[`MSC_C_MAXEN];
  assign min_en = ctrl[`MSC_C_MINEN];

  logic wr;
  logic rd_acc;
  assign wr     = psel & penable & pwrite;
  assign rd_acc = psel & ~penable;

  logic signed [31:0] live;
  logic signed [31:0] minv;
  logic signed [31:0] maxv;
  logic signed [31:0] raw;
  logic               zero_evt;
  logic               load_min;
  logic               load_max;
  logic [7:0]         cmd_code;
  logic               cmd_wr;
  msc_pkg::msc_sv_t   sv;
  assign raw    = $signed(raw_reading);
  assign cmd_wr = wr && (paddr == `MSC_A_CMD);
  assign cmd_code = pwdata[7:0];

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= 12'h000;
      inp1       <= 32'sd0;
      dsp1       <= 32'sd0;
      inp2       <= `MSC_INP_MAX;
      dsp2       <= `MSC_INP_MAX;
      delays     <= 32'h0;
      apply_live <= 1'b0;
    end else if (cmd_wr && cmd_code == `MSC_CODE_DEFAULTS && sv == msc_pkg::MSC_SV_IDLE) begin
      ctrl       <= 12'h000;
      inp1       <= 32'sd0;
      dsp1       <= 32'sd0;
      inp2       <= `MSC_INP_MAX;
      dsp2       <= `MSC_INP_MAX;
      delays     <= 32'h0;
      apply_live <= 1'b0;
    end else if (wr) begin
      if (paddr == `MSC_A_CTRL) begin
        ctrl <= pwdata[11:0];
      end else if (paddr == `MSC_A_INP1) begin
        inp1 <= clampv($signed(pwdata), 32'sd0, `MSC_INP_MAX);
      end else if (paddr == `MSC_A_DSP1) begin
        dsp1 <= clampv($signed(pwdata), `MSC_DISP_MIN, `MSC_DISP_MAX);
      end else if (paddr == `MSC_A_INP2) begin
        if (ctrl[`MSC_C_APPLY] && apply_live) begin
          inp2 <= clampv(raw, 32'sd0, `MSC_INP_MAX);
        end else if (!ctrl[`MSC_C_APPLY]) begin
          inp2 <= clampv($signed(pwdata), 32'sd0, `MSC_INP_MAX);
        end
        apply_live <= 1'b0;
      end else if (paddr == `MSC_A_DSP2) begin
        dsp2 <= clampv($signed(pwdata), `MSC_DISP_MIN, `MSC_DISP_MAX);
      end else if (paddr == `MSC_A_DELAY) begin
        delays <= {(pwdata[31:16] > `MSC_DELAY_MAX) ? `MSC_DELAY_MAX : pwdata[31:16],
                   (pwdata[15:0] > `MSC_DELAY_MAX) ? `MSC_DELAY_MAX : pwdata[15:0]};
      end
    end else if (ctrl[`MSC_C_APPLY] && rb_edge) begin
      apply_live <= 1'b1;
    end
  end

  // scaling
  logic signed [31:0] scaled;
  msc_scaler u_scaler (
    .pclk    (pclk),
    .presetn (presetn),
    .inp1    (inp1),
    .dsp1    (dsp1),
    .inp2    (inp2),
    .dsp2    (dsp2),
    .offset  (offset),
    .raw     (raw),
    .scaled  (scaled)
  );
  assign live = scaled;

  // seconds timebase
  logic [31:0] cyc;
  logic        sec_tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc      <= 32'h0;
      sec_tick <= 1'b0;
    end else if (cyc == 32'(SEC_CYC - 1)) begin
      cyc      <= 32'h0;
      sec_tick <= 1'b1;
    end else begin
      cyc      <= cyc + 32'h1;
      sec_tick <= 1'b0;
    end
  end

  // user input dispatch
  logic is_assigned_fn;
  logic ui_reset;
  logic prrst_pend;
  assign is_assigned_fn = (fn == msc_pkg::MSC_FN_RESET) || (fn == msc_pkg::MSC_FN_HOLD) ||
                          (fn == msc_pkg::MSC_FN_PRRST);
  assign ui_reset = (ui_edge && fn == msc_pkg::MSC_FN_RESET) || prrst_pend;
  assign load_min = ui_reset && is_assigned_fn &&
                    (asg == msc_pkg::MSC_ASG_MIN || asg == msc_pkg::MSC_ASG_BOTH);
  assign load_max = ui_reset && is_assigned_fn &&
                    (asg == msc_pkg::MSC_ASG_MAX || asg == msc_pkg::MSC_ASG_BOTH);
  assign zero_evt = (ui_edge && fn == msc_pkg::MSC_FN_ZERO) ||
                    (ctrl[`MSC_C_ZOR] && rb_edge && asg == msc_pkg::MSC_ASG_INPUT &&
                     shown_sel == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset <= 32'sd0;
    end else if (wr && paddr == `MSC_A_OFFSET) begin
      offset <= $signed(pwdata);
    end else if (zero_evt) begin
      offset <= offset - live;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      print_req  <= 1'b0;
      prrst_pend <= 1'b0;
      sp1_clear  <= 1'b0;
      sp2_clear  <= 1'b0;
    end else begin
      print_req  <= ui_edge && (fn == msc_pkg::MSC_FN_PRINT || fn == msc_pkg::MSC_FN_PRRST);
      prrst_pend <= ui_edge && fn == msc_pkg::MSC_FN_PRRST;
      sp1_clear  <= ui_edge && (fn == msc_pkg::MSC_FN_SP1 || fn == msc_pkg::MSC_FN_SP12);
      sp2_clear  <= ui_edge && (fn == msc_pkg::MSC_FN_SP2 || fn == msc_pkg::MSC_FN_SP12);
    end
  end

  // backlight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intensity   <= 3'h5;
      color_green <= 1'b0;
    end else if (ctrl[`MSC_C_BACKLIT] && ui_edge) begin
      if (fn == msc_pkg::MSC_FN_INTEN) begin
        intensity <= (intensity == 3'h5) ? 3'h1 : intensity + 3'h1;
      end else if (fn == msc_pkg::MSC_FN_COLOR) begin
        color_green <= ~color_green;
      end
    end
  end

  // captures
  msc_capture #(.IS_MAX(1'b1)) u_max (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (max_en),
    .sec_tick (sec_tick),
    .delay_s  (delays[31:16]),
    .load     (load_max),
    .live     (live),
    .extreme  (maxv)
  );
  msc_capture #(.IS_MAX(1'b0)) u_min (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (min_en),
    .sec_tick (sec_tick),
    .delay_s  (delays[15:0]),
    .load     (load_min),
    .live     (live),
    .extreme  (minv)
  );

  // display selection and scroll
  logic [2:0] scr_secs;
  logic       advance;
  logic       scroll_on;
  assign scroll_on = ctrl[`MSC_C_SCROLL] && (max_en || min_en);
  assign advance   = (ui_edge && fn == msc_pkg::MSC_FN_ADV) ||
                     (scroll_on && sec_tick && scr_secs == 3'(SCRL_S - 1));
  function automatic logic [1:0] next_disp(input logic [1:0] s, input logic mx,
                                           input logic mn);
    next_disp = 2'h0;
    if (s == 2'h0 && mx) next_disp = 2'h1;
    else if (s == 2'h0 && mn) next_disp = 2'h2;
    else if (s == 2'h1 && mn) next_disp = 2'h2;
  endfunction : next_disp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_secs  <= 3'h0;
      shown_sel <= 2'h0;
    end else begin
      if (!scroll_on || advance) begin
        scr_secs <= 3'h0;
      end else if (sec_tick) begin
        scr_secs <= scr_secs + 3'h1;
      end
      if (advance) begin
        shown_sel <= next_disp(shown_sel, max_en, min_en);
      end
    end
  end

  logic hold;
  logic signed [31:0] pick;
  assign hold = ui_s[1] && fn == msc_pkg::MSC_FN_HOLD;
  assign pick = (shown_sel == 2'h1) ? maxv : ((shown_sel == 2'h2) ? minv : live);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_value <= 32'h0;
    end else if (!(hold && (asg == msc_pkg::MSC_ASG_BOTH ||
                 (asg == msc_pkg::MSC_ASG_INPUT && shown_sel == 2'h0) ||
                 (asg == msc_pkg::MSC_ASG_MAX && shown_sel == 2'h1) ||
                 (asg == msc_pkg::MSC_ASG_MIN && shown_sel == 2'h2)))) begin
      display_value <= pick;
    end
  end

  // service codes and calibration
  logic [31:0] sv_cnt;
  logic [1:0]  cal_rng;
  logic        cal_half;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sv       <= msc_pkg::MSC_SV_IDLE;
      sv_cnt   <= 32'h0;
      cal_rng  <= 2'h0;
      cal_busy <= 1'b0;
      cal_half <= 1'b0;
    end else begin
      case (sv)
        msc_pkg::MSC_SV_IDLE: begin
          cal_busy <= 1'b0;
          sv_cnt   <= 32'h0;
          if (cmd_wr && cmd_code == `MSC_CODE_DEFAULTS) begin
            sv <= msc_pkg::MSC_SV_RESET;
          end else if (cmd_wr && cmd_code == `MSC_CODE_VERSION) begin
            sv <= msc_pkg::MSC_SV_VER;
          end else if (cmd_wr && pwdata[8]) begin
            sv       <= msc_pkg::MSC_SV_CALZ;
            cal_rng  <= pwdata[10:9];
            cal_busy <= 1'b1;
          end
        end
        msc_pkg::MSC_SV_RESET, msc_pkg::MSC_SV_VER: begin
          if (sec_tick) sv_cnt <= sv_cnt + 32'h1;
          if (sec_tick && sv_cnt != 32'h0) sv <= msc_pkg::MSC_SV_IDLE;
        end
        msc_pkg::MSC_SV_CALZ: begin
          if (sec_tick) sv_cnt <= sv_cnt + 32'h1;
          if (sv_cnt == 32'(CALZ_S)) begin
            sv       <= msc_pkg::MSC_SV_CALF;
            cal_busy <= 1'b0;
            cal_half <= (cal_rng == `MSC_CAL_HALF_RNG);
          end
        end
        msc_pkg::MSC_SV_CALF: begin
          if (cmd_wr) sv <= msc_pkg::MSC_SV_IDLE;
        end
        default: sv <= msc_pkg::MSC_SV_IDLE;
      endcase
    end
  end

  // apb read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end else if (rd_acc) begin
      pslverr <= (paddr > `MSC_A_CMD) || (paddr[1:0] != 2'h0);
      if (paddr == `MSC_A_CTRL) prdata <= {20'h0, ctrl};
      else if (paddr == `MSC_A_INP1) prdata <= inp1;
      else if (paddr == `MSC_A_DSP1) prdata <= dsp1;
      else if (paddr == `MSC_A_INP2) prdata <= (ctrl[`MSC_C_APPLY] && apply_live) ? raw : inp2;
      else if (paddr == `MSC_A_DSP2) prdata <= dsp2;
      else if (paddr == `MSC_A_OFFSET) prdata <= offset;
      else if (paddr == `MSC_A_DELAY) prdata <= delays;
      else if (paddr == `MSC_A_LIVE) prdata <= live;
      else if (paddr == `MSC_A_MINV) prdata <= minv;
      else if (paddr == `MSC_A_MAXV) prdata <= maxv;
      else if (paddr == `MSC_A_SHOWN) prdata <= {30'h0, shown_sel};
      else if (paddr == `MSC_A_STATUS) prdata <= {26'h0, cal_half, cal_busy, 1'b0, sv};
      else prdata <= 32'h0;
    end
  end

  a_zero_offset: assert property (@(posedge pclk) disable iff (!presetn)
    (zero_evt && !(wr && paddr == `MSC_A_OFFSET)) |=> (offset == $past(offset) - $past(live)))
    else $error("zero did not adjust offset");
  a_prrst_order: assert property (@(posedge pclk) disable iff (!presetn)
    (ui_edge && fn == msc_pkg::MSC_FN_PRRST) |=> print_req ##0 prrst_pend)
    else $error("print and reset order wrong");
  a_sp_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ui_edge && fn == msc_pkg::MSC_FN_SP12) |=> (sp1_clear && sp2_clear))
    else $error("setpoint reset missing");
  a_assign_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !is_assigned_fn |-> !(load_min || load_max))
    else $error("assignment used for other function");
  a_select_step: assert property (@(posedge pclk) disable iff (!presetn)
    (ui_edge && fn == msc_pkg::MSC_FN_ADV) |=>
      (shown_sel == next_disp($past(shown_sel), $past(max_en), $past(min_en))))
    else $error("display select did not advance once");
  a_scroll_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!scroll_on && !(ui_edge && fn == msc_pkg::MSC_FN_ADV)) |=> $stable(shown_sel))
    else $error("scroll without min or max");
  a_zor_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (zero_evt && fn != msc_pkg::MSC_FN_ZERO) |-> (shown_sel == 2'h0))
    else $error("zero on reset while input not shown");
  a_cal_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (sv == msc_pkg::MSC_SV_CALZ) |-> cal_busy)
    else $error("busy not shown during zero step");
endmodule : msc_meter

// *** tb/msc_panel.sv ***
// front panel buttons, user input line and current source model
`timescale 1ns/100ps
module msc_panel (
  // clock
  input  wire logic   pclk,
  // panel lines
  output logic        user_in,
  output logic        rst_btn,
  output logic [31:0] raw_reading
);
  initial begin
    user_in = 1'b0;
    rst_btn = 1'b0;
    raw_reading = 32'h0;
  end
  // level on the user input or the reset button
  task automatic level(input bit btn, input bit v);
    @(posedge pclk);
    if (btn) begin
      rst_btn <= v;
    end else begin
      user_in <= v;
    end
    repeat (8) @(posedge pclk);
  endtask : level
  // one activation, long enough for the synchroniser
  task automatic pulse(input bit btn);
    level(btn, 1'b1);
    level(btn, 1'b0);
  endtask : pulse
  // source value; drives raw_reading with v, then waits four cycles
  task automatic source(input logic [31:0] v);
    @(posedge pclk);
    raw_reading <= v;
    repeat (4) @(posedge pclk);
  endtask : source
endmodule : msc_panel

// *** tb/tb_msc_meter.sv ***
// self-checking bench for the meter scaling and capture logic
`timescale 1ns/100ps
`include "msc_defs.svh"
module tb_msc_meter;
  logic             pclk, presetn, psel, penable, pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, q;
  wire logic        pready, pslverr, user_in, rst_btn, print_req, sp1_clear, sp2_clear;
  wire logic        color_green, cal_busy;
  wire logic [31:0] prdata, display_value, raw_reading;
  wire logic [1:0]  shown_sel;
  wire logic [2:0]  intensity;
  int          n_fail, checked, n_pr, n_s1, n_s2, b1, b2, bp;
  msc_meter #(.CLK_HZ(100)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_in(user_in), .rst_btn(rst_btn),
    .raw_reading(raw_reading), .display_value(display_value), .shown_sel(shown_sel),
    .print_req(print_req), .sp1_clear(sp1_clear), .sp2_clear(sp2_clear),
    .intensity(intensity), .color_green(color_green), .cal_busy(cal_busy));
  msc_panel i_pan (.pclk(pclk), .user_in(user_in), .rst_btn(rst_btn),
    .raw_reading(raw_reading));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // count one-cycle pulses
  always @(posedge pclk) begin
    n_pr <= n_pr + int'(print_req === 1'b1);
    n_s1 <= n_s1 + int'(sp1_clear === 1'b1);
    n_s2 <= n_s2 + int'(sp2_clear === 1'b1);
  end
  task automatic wrap_up;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] cw(msc_pkg::msc_fn_t f, msc_pkg::msc_asg_t g, int b);
    return {26'h0, g, f} | (32'h1 << b);
  endfunction : cw
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    q       = 32'h0;
    {n_fail, checked, n_pr, n_s1, n_s2} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("intensity", intensity, 32'h5);
    chk("pready", pready, 32'h1);
    apb(1, `MSC_A_INP2, 32'h7530);
    rd(`MSC_A_INP2);
    chk("inp2 clamp", q, 32'h752f);
    apb(1, `MSC_A_DSP1, 32'h186a0);
    rd(`MSC_A_DSP1);
    chk("dsp1 hi", q, 32'h1869f);
    apb(1, `MSC_A_DSP1, 32'hffffb1e0);
    rd(`MSC_A_DSP1);
    chk("dsp1 lo", q, 32'hffffb1e1);
    apb(1, `MSC_A_DSP1, 32'h0);
    apb(1, `MSC_A_INP1, 32'h0);
    apb(1, `MSC_A_INP2, 32'h3e8);
    apb(1, `MSC_A_DSP2, 32'h7d0);
    i_pan.source(32'h7d0);
    rd(`MSC_A_LIVE);
    chk("extrapolated", q, 32'hfa0);
    chk("display", display_value, 32'hfa0);
    rd(12'h040);
    chk("unmapped err", pslverr, 32'h1);
    $display("scaling test done");
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_ZERO, msc_pkg::MSC_ASG_MAX, 12));
    i_pan.source(32'h1f4);
    i_pan.pulse(0);
    rd(`MSC_A_LIVE);
    chk("zeroed", q, 32'h0);
    rd(`MSC_A_OFFSET);
    chk("offset", q, 32'hfffffc18);
    apb(1, `MSC_A_OFFSET, 32'h0);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_NONE, msc_pkg::MSC_ASG_INPUT, 10));
    i_pan.pulse(1);
    rd(`MSC_A_OFFSET);
    chk("zero on reset", q, 32'hfffffc18);
    apb(1, `MSC_A_OFFSET, 32'h0);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_RESET, msc_pkg::MSC_ASG_BOTH, 12));
    i_pan.source(32'h5dc);
    i_pan.pulse(0);
    rd(`MSC_A_MINV);
    chk("min load", q, 32'hbb8);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_RESET, msc_pkg::MSC_ASG_MIN, 12));
    i_pan.source(32'hfa);
    i_pan.pulse(0);
    rd(`MSC_A_MINV);
    chk("min only", q, 32'h1f4);
    rd(`MSC_A_MAXV);
    chk("max kept", q, 32'hbb8);
    $display("reset test done");
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_HOLD, msc_pkg::MSC_ASG_INPUT, 12));
    i_pan.level(0, 1);
    i_pan.source(32'h3e8);
    chk("held", display_value, 32'h1f4);
    rd(`MSC_A_LIVE);
    chk("live runs", q, 32'h7d0);
    i_pan.level(0, 0);
    chk("released", display_value, 32'h7d0);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_ADV, msc_pkg::MSC_ASG_INPUT, 6) | 32'h80);
    for (int i = 1; i < 4; i++) begin
      i_pan.pulse(0);
      chk("shown", shown_sel, i % 3);
    end
    $display("display test done");
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_INTEN, msc_pkg::MSC_ASG_INPUT, 11));
    i_pan.pulse(0);
    chk("intensity wrap", intensity, 32'h1);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_COLOR, msc_pkg::MSC_ASG_INPUT, 11));
    i_pan.pulse(0);
    chk("color", color_green, 32'h1);
    for (int f = 10; f < 13; f++) begin
      apb(1, `MSC_A_CTRL, cw(msc_pkg::msc_fn_t'(f), msc_pkg::MSC_ASG_INPUT, 12));
      {b1, b2} = {n_s1, n_s2};
      i_pan.pulse(0);
      chk("sp1 clear", n_s1 - b1, f != 11);
      chk("sp2 clear", n_s2 - b2, f != 10);
    end
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_PRRST, msc_pkg::MSC_ASG_MAX, 12));
    bp = n_pr;
    i_pan.source(32'h12c);
    i_pan.pulse(0);
    chk("print", n_pr - bp, 32'h1);
    rd(`MSC_A_MAXV);
    chk("print max", q, 32'h258);
    $display("user input test done");
    apb(1, `MSC_A_DELAY, 32'h0002_0002);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_NONE, msc_pkg::MSC_ASG_INPUT, 6) | 32'h100);
    i_pan.source(32'h7d0);
    repeat (60) @(posedge pclk);
    rd(`MSC_A_MAXV);
    chk("max early", q, 32'h258);
    repeat (400) @(posedge pclk);
    rd(`MSC_A_MAXV);
    chk("max captured", q, 32'hfa0);
    chk("scroll", shown_sel, 32'h1);
    i_pan.source(32'h32);
    repeat (500) @(posedge pclk);
    rd(`MSC_A_MINV);
    chk("min disabled", q, 32'h1f4);
    apb(1, `MSC_A_CTRL, cw(msc_pkg::MSC_FN_NONE, msc_pkg::MSC_ASG_INPUT, 7));
    repeat (500) @(posedge pclk);
    rd(`MSC_A_MINV);
    chk("min captured", q, 32'h64);
    $display("capture test done");
    apb(1, `MSC_A_CMD, 32'h42);
    rd(`MSC_A_STATUS);
    chk("defaults", q & 32'h7, 32'h1);
    rd(`MSC_A_DELAY);
    chk("defaults delay", q, 32'h0);
    repeat (250) @(posedge pclk);
    rd(`MSC_A_STATUS);
    chk("prompt", q & 32'h7, 32'h0);
    apb(1, `MSC_A_CMD, 32'h32);
    rd(`MSC_A_STATUS);
    chk("version", q & 32'h7, 32'h2);
    repeat (250) @(posedge pclk);
    i_pan.source(32'h0);
    apb(1, `MSC_A_CMD, 32'h700);
    @(negedge pclk);
    chk("cal busy", cal_busy, 32'h1);
    rd(`MSC_A_STATUS);
    chk("cal zero", q & 32'h37, 32'h13);
    repeat (600) @(posedge pclk);
    chk("busy 6s", cal_busy, 32'h1);
    repeat (400) @(posedge pclk);
    chk("busy end", cal_busy, 32'h0);
    rd(`MSC_A_STATUS);
    chk("full step", q & 32'h7, 32'h4);
    chk("cal half", q & 32'h20, 32'h20);
    apb(1, `MSC_A_CMD, 32'h0);
    rd(`MSC_A_STATUS);
    chk("cal done", q & 32'h7, 32'h0);
    apb(1, `MSC_A_CTRL, 32'h200);
    i_pan.source(32'h3e8);
    apb(1, `MSC_A_INP2, 32'h5);
    rd(`MSC_A_INP2);
    chk("apply keeps", q, 32'h752f);
    i_pan.pulse(1);
    rd(`MSC_A_INP2);
    chk("apply live", q, 32'h3e8);
    apb(1, `MSC_A_INP2, 32'h5);
    i_pan.source(32'h7);
    rd(`MSC_A_INP2);
    chk("apply stores", q, 32'h3e8);
    $display("service test done");
    wrap_up();
  end
endmodule : tb_msc_meter
